/* File: bench/mmt_transition_properties.sv */
`timescale 1ns/10ps
module mmt_transition_properties (
	input wire logic sys_clk,      // Core clock.
	input wire logic resetn,       // Reset, active low.
	input wire logic mgmtExitReq,  // Exit request.
	input wire logic entryReq,     // Entry request.
	input wire logic resumeInstr,  // Resume instruction.
	input wire logic iretInstr,    // Interrupt return.
	input wire logic entryMgmtCtl, // Entry-to-management control.
	input wire logic mgmtMode,     // Management mode.
	input wire logic dualActive,   // Dual treatment active.
	input wire logic hostMode,     // Host mode.
	input wire logic nmiBlocked,   // NMI blocking.
	input wire logic mgmtIntBlock, // Management interrupt blocking.
	input wire logic flushVpid0,   // Id-zero flush.
	input wire logic flushAll,     // Full flush.
	input wire logic timerStart,   // Timer start.
	input wire logic entryDone,    // Entry success.
	input wire logic entryFail,    // Entry failure.
	input wire logic invOpcode,    // Invalid opcode.
	input wire logic resumeExit,   // Resume exit.
	input wire logic inducedOk     // Induced exits allowed.
);
	// ---------------------------------------------------------------
	// Transition checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_exit_take;
		mgmtExitReq && !mgmtMode;
	endsequence
	sequence s_exit_done;
		mgmtMode && nmiBlocked && mgmtIntBlock && flushVpid0;
	endsequence
	sequence s_entry_take;
		entryReq && mgmtMode && dualActive && !entryMgmtCtl;
	endsequence

	a_exit_blocks: assert property (s_exit_take |=> s_exit_done)
		else $error("exit did not block and flush");
	a_entry_ends: assert property (s_entry_take |-> ##[2:3] (entryDone || entryFail))
		else $error("entry gave no outcome in time");
	a_resume_host: assert property (resumeInstr && mgmtMode && dualActive && hostMode
		|=> invOpcode && !resumeExit) else $error("resume in host mode not refused");
	a_smi_release: assert property ($fell(mgmtIntBlock) |-> entryDone)
		else $error("management blocking released without entry");
	a_nmi_release: assert property ($fell(nmiBlocked) |-> entryDone || $past(iretInstr))
		else $error("nmi blocking released without cause");
	a_entry_flush: assert property (entryDone |-> flushAll && $fell(mgmtMode))
		else $error("entry without full flush or mode change");
	a_timer_guest: assert property (timerStart |-> entryDone && !hostMode)
		else $error("timer started outside guest entry");
	a_fail_stays: assert property (entryFail |-> mgmtMode && !entryDone)
		else $error("failed entry left management mode");
	a_induced_guest: assert property ($rose(inducedOk) |-> entryDone && !hostMode)
		else $error("induced exits allowed outside guest entry");
endmodule : mmt_transition_properties

bind mmt_transition mmt_transition_properties i_props (.sys_clk, .resetn, .mgmtExitReq,
	.entryReq, .resumeInstr, .iretInstr, .entryMgmtCtl, .mgmtMode, .dualActive, .hostMode,
	.nmiBlocked, .mgmtIntBlock, .flushVpid0, .flushAll, .timerStart, .entryDone, .entryFail,
	.invOpcode, .resumeExit, .inducedOk);

/* File: bench/test_mgmt_mode_monitor_transitions.sv */
`timescale 1ns/10ps
module test_mgmt_mode_monitor_transitions import mmt_pkg::*; ;
	// ---------------------------------------------------------------
	// Stimulus and checks
	// ---------------------------------------------------------------
	localparam logic [63:0] ROOT = 64'h0000_0000_0012_3000;
	localparam logic [63:0] LINK = 64'h0000_0000_0045_6000;
	localparam logic [63:0] GST  = 64'h0000_0000_0078_9000;
	localparam logic [63:0] XFR  = 64'h0000_0000_00ab_c000;
	localparam logic [31:0] REV  = 32'h0000_0011;
	logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata, timerLoad, injectInfo;
	logic        pready, pslverr, err;
	logic        mgmtExitReq = 1'b0, entryReq = 1'b0, resumeInstr = 1'b0, iretInstr = 1'b0;
	logic        saveTmrCtl = 1'b0, actTmrCtl = 1'b0, execActTmr = 1'b0, execCtlOk = 1'b1;
	logic        guestChkOk = 1'b1, loadFail = 1'b0, execLaunched = 1'b1, deactCtl = 1'b0;
	logic        entryMgmtCtl = 1'b0, secureLaunch = 1'b0, virtNmiCtl = 1'b0;
	logic [15:0] exitReason = 16'h0;
	logic [31:0] timerNow = 32'h0, timerField = 32'h0, execRevWord = REV, revisionId = REV;
	logic [31:0] injInfo = 32'h0, intrState = 32'h0;
	logic [63:0] rootPtr = ROOT, linkPtr = LINK, execPtrFld = GST, v;
	logic [1:0]  activity = 2'h0;
	logic        mgmtMode, dualActive, hostMode, nmiBlocked, mgmtIntBlock, flushVpid0, flushAll;
	logic        timerStart, injectGo, entryDone, entryFail, invOpcode, resumeExit, inducedOk;
	int          n_fail = 0;
	int          n_checks = 0;

	mmt_transition i_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .mgmtExitReq, .exitReason, .entryReq, .resumeInstr, .iretInstr,
		.saveTmrCtl, .actTmrCtl, .execActTmr, .execCtlOk, .guestChkOk, .loadFail, .timerNow,
		.timerField, .rootPtr, .linkPtr, .execPtrFld, .execRevWord, .revisionId, .execLaunched,
		.deactCtl, .entryMgmtCtl, .injInfo, .activity, .intrState, .secureLaunch, .virtNmiCtl,
		.mgmtMode, .dualActive, .hostMode, .nmiBlocked, .mgmtIntBlock, .flushVpid0, .flushAll,
		.timerStart, .timerLoad, .injectGo, .injectInfo, .entryDone, .entryFail, .invOpcode,
		.resumeExit, .inducedOk);

	initial forever #4 sys_clk = ~sys_clk;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Holds the request until pready is sampled high, as the bus requires, giving up after 20 cycles.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n = 0;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			n_fail++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk64(input logic [7:0] a, input logic [63:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		v[31:0] = rd;
		apb(1'b0, a + 8'h04, 32'h0);
		v[63:32] = rd;
		chk(v, exp, what);
	endtask : chk64

	task automatic go_exit(input logic [15:0] r);
		@(posedge sys_clk);
		exitReason  <= r;
		mgmtExitReq <= 1'b1;
		@(posedge sys_clk);
		mgmtExitReq <= 1'b0;
		#1;
		chk({mgmtMode, nmiBlocked, mgmtIntBlock, flushVpid0}, 4'hf, "exit flags");
	endtask : go_exit

	// Waits a bounded span for the outcome pulse and leaves it visible.
	task automatic go_entry(input logic [63:0] p);
		int n = 0;
		@(posedge sys_clk);
		execPtrFld <= p;
		entryReq   <= 1'b1;
		@(posedge sys_clk);
		entryReq <= 1'b0;
		#1;
		while (entryDone !== 1'b1 && entryFail !== 1'b1 && n < 6) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : go_entry

	task automatic fail_case(input logic [63:0] p, input logic d, input logic l,
		input logic [31:0] rw, input logic [31:0] inj, input logic [1:0] act, input mmt_fault_t f);
		deactCtl     <= d;
		execLaunched <= l;
		execRevWord  <= rw;
		injInfo      <= inj;
		activity     <= act;
		go_entry(p);
		chk({entryFail, mgmtMode}, 2'b11, "refused entry");
		apb(1'b0, A_STATUS, 32'h0);
		chk(rd[9:7], f, "fault code");
	endtask : fail_case

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic t_regs();
		apb(1'b0, A_STATUS, 32'h0);
		chk(rd[4:0], 5'h04, "status after reset");
		apb(1'b1, A_CTRL, 32'h1);
		apb(1'b0, A_CTRL, 32'h0);
		chk(rd[0], 1'b1, "control readback");
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1, "unmapped access");
		apb(1'b1, A_MGMTBASE, 32'h0003_0000);
		apb(1'b1, A_XFRPTR_L, XFR[31:0]);
		apb(1'b1, A_XFRPTR_H, XFR[63:32]);
	endtask : t_regs

	task automatic t_exit_host();
		go_exit(16'h0022);
		apb(1'b0, A_REASON, 32'h0);
		chk(rd, 32'h2000_0022, "reason from host");
		apb(1'b0, A_SAVEDBASE, 32'h0);
		chk(rd, 32'h0003_0000, "saved base");
		chk64(A_EXECPTR_L, ROOT, "executive pointer");
		chk64(A_CURPTR_L, XFR, "current pointer");
		@(posedge sys_clk);
		resumeInstr <= 1'b1;
		@(posedge sys_clk);
		resumeInstr <= 1'b0;
		#1;
		chk({invOpcode, resumeExit}, 2'b10, "resume in host mode");
	endtask : t_exit_host

	task automatic t_refusals();
		fail_case(GST | 64'h10, 1'b0, 1'b1, REV, 32'h0, 2'h0, MMT_F_ALIGN);
		fail_case(GST | 64'h4000_0000_0000, 1'b0, 1'b1, REV, 32'h0, 2'h0, MMT_F_WIDTH);
		fail_case(GST, 1'b0, 1'b1, REV + 32'h1, 32'h0, 2'h0, MMT_F_REV);
		fail_case(GST, 1'b0, 1'b0, REV, 32'h0, 2'h0, MMT_F_LAUNCH);
		fail_case(GST, 1'b1, 1'b1, REV, 32'h0, 2'h0, MMT_F_DEACT);
		fail_case(ROOT, 1'b0, 1'b1, REV, 32'h8000_0105, 2'h0, MMT_F_INJ);
		fail_case(ROOT, 1'b0, 1'b1, REV, 32'h0, ACT_WAIT_START, MMT_F_ACT);
		for (int i = 0; i < 3; i++) begin
			execCtlOk  <= (i != 0);
			guestChkOk <= (i != 1);
			loadFail   <= (i == 2);
			go_entry(GST);
			chk({entryFail, mgmtMode}, 2'b11, "late failure");
		end
		guestChkOk   <= 1'b1;
		loadFail     <= 1'b0;
		entryMgmtCtl <= 1'b1;
		go_entry(GST);
		chk({entryDone, entryFail}, 2'b00, "entry into management ignored");
		entryMgmtCtl <= 1'b0;
	endtask : t_refusals

	task automatic t_entry_host();
		injInfo   <= 32'h8000_0700;
		intrState <= 32'h4;
		activity  <= 2'h0;
		apb(1'b1, A_MGMTBASE, 32'h0004_0000);
		go_entry(ROOT);
		chk({entryDone, mgmtMode, hostMode, flushAll, timerStart}, 5'b10110, "host entry");
		chk(mgmtIntBlock, 1'b1, "blocking from interruptibility");
		chk64(A_CURPTR_L, LINK, "current from link");
		chk64(A_XFRPTR_L, XFR, "transfer pointer");
		apb(1'b0, A_MGMTBASE, 32'h0);
		chk(rd, 32'h0003_0000, "base reloaded");
	endtask : t_entry_host

	task automatic t_guest_round();
		go_exit(16'h0001);
		execCtlOk  <= 1'b1;
		execActTmr <= 1'b1;
		timerField <= 32'h0000_0500;
		intrState  <= 32'h0;
		injInfo    <= 32'h0;
		go_entry(GST);
		chk({entryDone, hostMode, timerStart, inducedOk}, 4'b1011, "guest entry");
		chk(timerLoad, 32'h0000_0500, "timer start value");
		chk(mgmtIntBlock, 1'b0, "blocking cleared");
		chk64(A_CURPTR_L, GST, "current from executive");
		saveTmrCtl <= 1'b1;
		actTmrCtl  <= 1'b1;
		timerNow   <= 32'h0000_0123;
		go_exit(16'h0001);
		apb(1'b0, A_REASON, 32'h0);
		chk(rd, 32'h0000_0001, "reason from guest");
		chk64(A_EXECPTR_L, GST, "executive from current");
		apb(1'b0, A_SAVEDTMR, 32'h0);
		chk(rd, 32'h0000_0123, "saved timer");
		@(posedge sys_clk);
		iretInstr <= 1'b1;
		@(posedge sys_clk);
		iretInstr <= 1'b0;
		#1;
		chk(nmiBlocked, 1'b0, "interrupt return unblocks");
		deactCtl     <= 1'b1;
		secureLaunch <= 1'b1;
		go_entry(ROOT);
		chk({entryDone, mgmtIntBlock, dualActive}, 3'b110, "deactivating entry");
	endtask : t_guest_round

	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_regs();
		t_exit_host();
		t_refusals();
		execCtlOk <= 1'b0;
		t_entry_host();
		t_guest_round();
		stop_test();
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		stop_test();
	end
endmodule : test_mgmt_mode_monitor_transitions

/* File: verilog/mmt_pkg.sv */
package mmt_pkg;

	// Widths of the architectural quantities handled by the transition unit.
	localparam int PTR_W        = 64;
	localparam int BASE_W       = 32;
	localparam int TMR_W        = 32;
	localparam int REASON_W     = 16;
	localparam int PA_W_DEFAULT = 46;

	// Alignment and field positions.
	localparam int PTR_ALIGN_HI  = 11;
	localparam int ROOT_LSB      = 12;
	localparam int ROOT_MSB      = 51;
	localparam int INJ_VALID_BIT = 31;
	localparam int INJ_TYPE_LSB  = 8;
	localparam int INJ_TYPE_MSB  = 10;
	localparam int INJ_VEC_MSB   = 7;
	localparam int ROOT_FLAG_BIT = 29;
	localparam int INTR_MGMT_BIT = 2;

	localparam logic [2:0]  INJ_TYPE_OTHER = 3'h7;
	localparam logic [7:0]  INJ_VEC_TRAP   = 8'h00;
	localparam logic [1:0]  ACT_WAIT_START = 2'h3;
	localparam logic [15:0] VIRTUAL_PROC_ID_ROOT      = 16'h0000;

	// APB register byte addresses.
	localparam logic [7:0] A_CTRL      = 8'h00;
	localparam logic [7:0] A_STATUS    = 8'h04;
	localparam logic [7:0] A_MGMTBASE  = 8'h08;
	localparam logic [7:0] A_SAVEDBASE = 8'h0c;
	localparam logic [7:0] A_SAVEDTMR  = 8'h10;
	localparam logic [7:0] A_REASON    = 8'h14;
	localparam logic [7:0] A_CURPTR_L  = 8'h18;
	localparam logic [7:0] A_CURPTR_H  = 8'h1c;
	localparam logic [7:0] A_XFRPTR_L  = 8'h20;
	localparam logic [7:0] A_XFRPTR_H  = 8'h24;
	localparam logic [7:0] A_EXECPTR_L = 8'h28;
	localparam logic [7:0] A_EXECPTR_H = 8'h2c;

	// Fault codes reported in the status register.
	typedef enum logic [2:0] {
		MMT_OK, MMT_F_ALIGN, MMT_F_WIDTH, MMT_F_REV, MMT_F_LAUNCH,
		MMT_F_DEACT, MMT_F_INJ, MMT_F_ACT
	} mmt_fault_t;

	typedef enum logic [1:0] {MMT_IDLE, MMT_CHECK, MMT_LOAD} mmt_state_t;

endpackage : mmt_pkg

/* File: verilog/mmt_transition.sv */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
// Summary of operation
// - Every management exit saves the management base into the guest area.
// - Save timer value when the save control is set; undefined from host or inactive timer.
// - Management exit sets NMI blocking; interrupt return clears it; entry loads interruptibility bit 0 unless virtual-NMI control keeps it.
// - Management exit blocks management interrupts; only a returning entry releases.
// - Exit invalidates id-zero translations for all context ids and table roots.
// - Resume instruction exits in guest mode, raises invalid opcode in host mode; handled only in management mode, always host, so never exits.
// - Leave management mode via entry; root pointer means staying in host mode.
// - Executive pointer: low 12 bits zero, within address width, revision matches.
// - Deactivate clear needs launched target; deactivate set needs the root pointer.
// - Control checks skipped in host mode, else on executive controls after alignment.
// - Returning entries skip the save-timer versus activate-timer consistency check.
// - Host-mode entry fails on valid injection of non-other type and non-zero vector.
// - Guest checks use zero controls in host mode, else executive controls.
// - Host-mode returning entry fails if activity selects wait-for-startup state.
// - Returning entry reloads the management base from its saved field.
// - Returning entry invalidates translations for all ids and table roots.
// - Timer starts only entering guest with executive activate set, from current value.
// - Success: transfer pointer gets current; current gets link or executive pointer.
// - Pointer updates precede injection; injection uses the original entry controls.
// - Induced exits only when entering guest, decided by the new current structure.
// - Management blocking after entry: interruptibility bit 2, or secure launch if deactivating.
// - Failed entry records an exit in old structure and stays in management mode.
// - Exit stores current or root pointer as executive; current takes transfer pointer.
// - Exit reason bit 29 is set only for exits from host mode.
module mmt_transition #(
	parameter int PA_W = mmt_pkg::PA_W_DEFAULT
) (
	input  wire logic                         sys_clk,      // Core clock.
	input  wire logic                         resetn,       // Asynchronous reset, active low.
	input  wire logic                         psel,         // APB select.
	input  wire logic                         penable,      // APB access phase.
	input  wire logic                         pwrite,       // APB write.
	input  wire logic [7:0]                   paddr,        // APB byte address.
	input  wire logic [31:0]                  pwdata,       // APB write data.
	output logic                              pready,       // APB ready.
	output logic      [31:0]                  prdata,       // APB read data.
	output logic                              pslverr,      // APB error on unmapped address.
	input  wire logic                         mgmtExitReq,  // Pulse: start a management exit.
	input  wire logic [mmt_pkg::REASON_W-1:0] exitReason,   // Basic exit reason.
	input  wire logic                         entryReq,     // Pulse: returning entry.
	input  wire logic                         resumeInstr,  // Pulse: resume instruction seen.
	input  wire logic                         iretInstr,    // Pulse: interrupt return.
	input  wire logic                         saveTmrCtl,   // Save-timer exit control.
	input  wire logic                         actTmrCtl,    // Activate-timer control, live.
	input  wire logic                         execActTmr,   // Executive activate-timer control.
	input  wire logic                         execCtlOk,    // Executive controls pass checks.
	input  wire logic                         guestChkOk,   // Guest checks pass, given ctl mode.
	input  wire logic                         loadFail,     // Failure during guest loading.
	input  wire logic [mmt_pkg::TMR_W-1:0]    timerNow,     // Running timer value.
	input  wire logic [mmt_pkg::TMR_W-1:0]    timerField,   // Timer-value field, current.
	input  wire logic [mmt_pkg::PTR_W-1:0]    rootPtr,      // Root-region pointer.
	input  wire logic [mmt_pkg::PTR_W-1:0]    linkPtr,      // Link-pointer field.
	input  wire logic [mmt_pkg::PTR_W-1:0]    execPtrFld,   // Executive pointer field.
	input  wire logic [31:0]                  execRevWord,  // Word at executive pointer.
	input  wire logic [31:0]                  revisionId,   // Structure revision id.
	input  wire logic                         execLaunched, // Executive structure launched.
	input  wire logic                         deactCtl,     // Deactivate-dual control.
	input  wire logic                         entryMgmtCtl, // Entry-to-management control.
	input  wire logic [31:0]                  injInfo,      // Injection field.
	input  wire logic [1:0]                   activity,     // Activity-state field.
	input  wire logic [31:0]                  intrState,    // Interruptibility-state field.
	input  wire logic                         secureLaunch, // Secure-launch operation.
	input  wire logic                         virtNmiCtl,   // Virtual-NMI control.
	output logic                              mgmtMode,     // In management mode.
	output logic                              dualActive,   // Dual treatment active.
	output logic                              hostMode,     // Host (root) mode.
	output logic                              nmiBlocked,   // NMI blocking.
	output logic                              mgmtIntBlock, // Management interrupt blocking.
	output logic                              flushVpid0,   // Pulse: flush id-zero maps.
	output logic                              flushAll,     // Pulse: flush all ids.
	output logic                              timerStart,   // Pulse: start timer.
	output logic      [mmt_pkg::TMR_W-1:0]    timerLoad,    // Timer start value.
	output logic                              injectGo,     // Pulse: inject event.
	output logic      [31:0]                  injectInfo,   // Injection info, old controls.
	output logic                              entryDone,    // Pulse: entry succeeded.
	output logic                              entryFail,    // Pulse: entry failed as exit.
	output logic                              invOpcode,    // Pulse: invalid opcode.
	output logic                              resumeExit,   // Pulse: resume causes exit.
	output logic                              inducedOk     // Induced exits allowed.
);
	import mmt_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		mmt_state_t        st;
		logic              mgmt, dual, host, nmiB, smiB;
		logic              enEnable;
		logic [BASE_W-1:0] base, savedBase;
		logic [TMR_W-1:0]  savedTmr, tmrLoad;
		logic              savedTmrValid;
		logic [31:0]       reason;
		logic [PTR_W-1:0]  cur, xfr, exec;
		logic              stayHost;
		mmt_fault_t        fault;
		logic [31:0]       injHold;
		logic              fVpid0, fAll, tStart, inj, done, fail, ud, rxit;
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
	} mmt_state_s_t;

	mmt_state_s_t s_r, s_nxt;
	logic [1:0]   rsync_r;
	logic         rstSync;

	// Reset release through two flops; the rest runs on the synchronised copy.
	// The chain stays outside the state struct so that the struct has one driver.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rsync_r <= 2'h0;
		end else begin
			rsync_r <= {rsync_r[0], 1'b1};
		end
	end
	assign rstSync = rsync_r[1];

	function automatic logic isRoot(input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] r);
		isRoot = (p == r);
	endfunction : isRoot

	function automatic logic [31:0] rd32(input logic [PTR_W-1:0] p, input logic hi);
		rd32 = hi ? p[PTR_W-1:32] : p[31:0];
	endfunction : rd32

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		logic root;
		logic injBad;
		root   = isRoot(execPtrFld, rootPtr);
		injBad = injInfo[INJ_VALID_BIT]
			&& (injInfo[INJ_TYPE_MSB:INJ_TYPE_LSB] != INJ_TYPE_OTHER)
			&& (injInfo[INJ_VEC_MSB:0] != INJ_VEC_TRAP);
		s_nxt       = s_r;
		s_nxt.fVpid0 = 1'b0;
		s_nxt.fAll   = 1'b0;
		s_nxt.tStart = 1'b0;
		s_nxt.inj    = 1'b0;
		s_nxt.done   = 1'b0;
		s_nxt.fail   = 1'b0;
		s_nxt.ud     = 1'b0;
		s_nxt.rxit   = 1'b0;

		if (iretInstr) begin
			s_nxt.nmiB = 1'b0;
		end
		// Resume is never legal under the dual treatment.
		if (resumeInstr && s_r.dual && s_r.mgmt) begin
			s_nxt.rxit = !s_r.host;
			s_nxt.ud   = s_r.host;
		end

		case (s_r.st)
			MMT_IDLE: begin
				if (mgmtExitReq && !s_r.mgmt) begin
					s_nxt.savedBase = s_r.base;
					if (saveTmrCtl) begin
						s_nxt.savedTmr      = timerNow;
						s_nxt.savedTmrValid = !s_r.host && actTmrCtl;
					end
					s_nxt.nmiB   = 1'b1;
					s_nxt.smiB   = 1'b1;
					s_nxt.fVpid0 = 1'b1;
					s_nxt.exec   = s_r.host ? rootPtr : s_r.cur;
					s_nxt.cur    = s_r.xfr;
					s_nxt.reason = {2'h0, s_r.host, 13'h0, exitReason};
					s_nxt.mgmt   = 1'b1;
					s_nxt.dual   = 1'b1;
					s_nxt.host   = 1'b1;
				end else if (entryReq && s_r.mgmt && s_r.dual && !entryMgmtCtl
						&& s_r.enEnable) begin
					s_nxt.st       = MMT_CHECK;
					s_nxt.stayHost = root;
					s_nxt.injHold  = injInfo;
					s_nxt.fault    = MMT_OK;
				end
			end
			MMT_CHECK: begin
				// Order: pointer checks, then launch/deactivate, then controls.
				if (execPtrFld[PTR_ALIGN_HI:0] != '0) begin
					s_nxt.fault = MMT_F_ALIGN;
				end else if (execPtrFld[PTR_W-1:PA_W] != '0) begin
					s_nxt.fault = MMT_F_WIDTH;
				end else if (execRevWord != revisionId) begin
					s_nxt.fault = MMT_F_REV;
				end else if (!deactCtl && !s_r.stayHost && !execLaunched) begin
					s_nxt.fault = MMT_F_LAUNCH;
				end else if (deactCtl && !s_r.stayHost) begin
					s_nxt.fault = MMT_F_DEACT;
				end else if (!s_r.stayHost && !execCtlOk) begin
					s_nxt.fault = MMT_F_INJ;
				end else if (s_r.stayHost && injBad) begin
					s_nxt.fault = MMT_F_INJ;
				end else if (s_r.stayHost && activity == ACT_WAIT_START) begin
					s_nxt.fault = MMT_F_ACT;
				end else if (!guestChkOk) begin
					s_nxt.fault = MMT_F_ACT;
				end
				s_nxt.st = MMT_LOAD;
				if (execPtrFld[PTR_ALIGN_HI:0] != '0 || execPtrFld[PTR_W-1:PA_W] != '0
						|| execRevWord != revisionId) begin
					// Failure before guest load: entry simply refused.
					s_nxt.st   = MMT_IDLE;
					s_nxt.fail = 1'b1;
				end
			end
			MMT_LOAD: begin
				s_nxt.st = MMT_IDLE;
				if (s_r.fault != MMT_OK || loadFail) begin
					// Exit recorded in the old structure; stay managed.
					s_nxt.fail = 1'b1;
					if (s_r.fault == MMT_OK) begin
						s_nxt.fault = MMT_F_ACT;
					end
				end else begin
					s_nxt.base  = s_r.savedBase;
					s_nxt.fAll  = 1'b1;
					s_nxt.tStart  = !s_r.stayHost && execActTmr;
					s_nxt.tmrLoad = timerField;
					s_nxt.xfr   = s_r.cur;
					s_nxt.cur   = s_r.stayHost ? linkPtr : execPtrFld;
					s_nxt.inj   = s_r.injHold[INJ_VALID_BIT];
					s_nxt.smiB  = deactCtl ? secureLaunch : intrState[INTR_MGMT_BIT];
					s_nxt.nmiB  = virtNmiCtl ? s_r.nmiB : intrState[0];
					s_nxt.mgmt  = 1'b0;
					s_nxt.dual  = !deactCtl;
					s_nxt.host  = s_r.stayHost;
					s_nxt.done  = 1'b1;
				end
			end
			default: s_nxt.st = MMT_IDLE;
		endcase

		// APB slave: data is registered in the first access cycle and a write lands only
		// at the edge where pready is seen high, so nothing commits before the handshake.
		s_nxt.pready  = psel && penable && !s_r.pready;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata  = 32'h0;
		if (psel && penable) begin
			case (paddr)
				A_CTRL: begin
					s_nxt.prdata = {31'h0, s_r.enEnable};
					if (pwrite && s_r.pready) begin
						s_nxt.enEnable = pwdata[0];
					end
				end
				A_STATUS: s_nxt.prdata = {21'h0, s_r.savedTmrValid, s_r.fault, s_r.st,
						s_r.smiB, s_r.nmiB, s_r.host, s_r.dual, s_r.mgmt};
				A_MGMTBASE: begin
					s_nxt.prdata = s_r.base;
					if (pwrite && s_r.pready) begin
						s_nxt.base = pwdata;
					end
				end
				A_SAVEDBASE: s_nxt.prdata = s_r.savedBase;
				A_SAVEDTMR:  s_nxt.prdata = s_r.savedTmr;
				A_REASON:    s_nxt.prdata = s_r.reason;
				A_CURPTR_L, A_CURPTR_H: s_nxt.prdata = rd32(s_r.cur, paddr[2]);
				A_XFRPTR_L, A_XFRPTR_H: begin
					s_nxt.prdata = rd32(s_r.xfr, paddr[2]);
					if (pwrite && s_r.pready && !paddr[2]) begin
						s_nxt.xfr[31:0] = pwdata;
					end else if (pwrite && s_r.pready) begin
						s_nxt.xfr[PTR_W-1:32] = pwdata;
					end
				end
				A_EXECPTR_L, A_EXECPTR_H: s_nxt.prdata = rd32(s_r.exec, paddr[2]);
				default: s_nxt.pslverr = !s_r.pready;
			endcase
		end
	end

	// Same flop vector, reset by rstSync, the synchronised copy from the sync chain.
	always_ff @(posedge sys_clk or negedge rstSync) begin
		if (!rstSync) begin
			{s_r.st, s_r.mgmt, s_r.dual, s_r.host, s_r.nmiB, s_r.smiB, s_r.enEnable}
				<= {MMT_IDLE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
			s_r.base <= '0; s_r.savedBase <= '0; s_r.savedTmr <= '0; s_r.tmrLoad <= '0;
			s_r.savedTmrValid <= 1'b0; s_r.reason <= '0;
			s_r.cur <= '0; s_r.xfr <= '0; s_r.exec <= '0; s_r.stayHost <= 1'b0;
			s_r.fault <= MMT_OK; s_r.injHold <= '0;
			{s_r.fVpid0, s_r.fAll, s_r.tStart, s_r.inj, s_r.done, s_r.fail, s_r.ud,
				s_r.rxit} <= 8'h00;
			s_r.pready <= 1'b0; s_r.prdata <= '0; s_r.pslverr <= 1'b0;
		end else begin
			{s_r.st, s_r.mgmt, s_r.dual, s_r.host, s_r.nmiB, s_r.smiB, s_r.enEnable}
				<= {s_nxt.st, s_nxt.mgmt, s_nxt.dual, s_nxt.host, s_nxt.nmiB,
					s_nxt.smiB, s_nxt.enEnable};
			s_r.base <= s_nxt.base; s_r.savedBase <= s_nxt.savedBase;
			s_r.savedTmr <= s_nxt.savedTmr; s_r.tmrLoad <= s_nxt.tmrLoad;
			s_r.savedTmrValid <= s_nxt.savedTmrValid; s_r.reason <= s_nxt.reason;
			s_r.cur <= s_nxt.cur; s_r.xfr <= s_nxt.xfr; s_r.exec <= s_nxt.exec;
			s_r.stayHost <= s_nxt.stayHost;
			s_r.fault <= s_nxt.fault; s_r.injHold <= s_nxt.injHold;
			{s_r.fVpid0, s_r.fAll, s_r.tStart, s_r.inj, s_r.done, s_r.fail, s_r.ud,
				s_r.rxit} <= {s_nxt.fVpid0, s_nxt.fAll, s_nxt.tStart, s_nxt.inj,
				s_nxt.done, s_nxt.fail, s_nxt.ud, s_nxt.rxit};
			s_r.pready <= s_nxt.pready; s_r.prdata <= s_nxt.prdata;
			s_r.pslverr <= s_nxt.pslverr;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign pready       = s_r.pready;
	assign prdata       = s_r.prdata;
	assign pslverr      = s_r.pslverr;
	assign mgmtMode     = s_r.mgmt;
	assign dualActive   = s_r.dual;
	assign hostMode     = s_r.host;
	assign nmiBlocked   = s_r.nmiB;
	assign mgmtIntBlock = s_r.smiB;
	assign flushVpid0   = s_r.fVpid0;
	assign flushAll     = s_r.fAll;
	assign timerStart   = s_r.tStart;
	assign timerLoad    = s_r.tmrLoad;
	assign injectGo     = s_r.inj;
	assign injectInfo   = s_r.injHold;
	assign entryDone    = s_r.done;
	assign entryFail    = s_r.fail;
	assign invOpcode    = s_r.ud;
	assign resumeExit   = s_r.rxit;
	assign inducedOk    = !s_r.mgmt && !s_r.host;

endmodule : mmt_transition
